// [move_exec_defines.svh]
// constants for the move-instruction execution block
// How it works
// - file copy goes to work or back
// - file copy always updates the zero flag
// - indirect load picks pointer, loads, sets zero
// - mode 00/01/10/11 pre/post inc/dec
// - relative form: pointer plus offset, pointer kept
// - window accesses go to the pointed address
// - pointers wrap modulo 16 bits
// - bank literal loads 5-bit bank, flags kept
// - pc latch literal loads 7 bits, flags kept
// - work literal loads 8 bits, flags kept
// - store writes work to file, flags kept
// - pointer steps never touch flags
`ifndef MOVE_EXEC_DEFINES_SVH
`define MOVE_EXEC_DEFINES_SVH
`define WORK_W 8
`define FILE_AW 7
`define FILE_DEPTH 128
`define PTR_W 16
`define BANK_W 5
`define PCL_W 7
`define OFS_W 6
`define WINDOW0_ADDR 7'h00
`define WINDOW1_ADDR 7'h01
`define WORK_RESET 8'h00
`define BANK_RESET 5'h00
`define PCL_RESET 7'h00
`define PTR_RESET 16'h0000
`define PTR_STEP 16'h0001
`endif

// [move_exec_pkg.sv]
// types shared by the move-instruction execution block
package move_exec_pkg;
  // operation selector, one-hot
  typedef enum logic [5:0] {
    FILE_COPY_OP        = 6'h01,
    INDIRECT_LOAD_OP    = 6'h02,
    BANK_LITERAL_OP     = 6'h04,
    PC_LATCH_LITERAL_OP = 6'h08,
    WORK_LITERAL_OP     = 6'h10,
    WORK_STORE_OP       = 6'h20
  } move_op_t;
  // pointer update mode field
  typedef enum logic [1:0] {
    PRE_INC  = 2'h0,
    PRE_DEC  = 2'h1,
    POST_INC = 2'h2,
    POST_DEC = 2'h3
  } pointer_update_mode_t;
endpackage

// [pointer_if.sv]
// carrier between the core and the pointer unit
`timescale 1ns/1ps
`default_nettype none
`include "move_exec_defines.svh"
interface pointer_if;
  import move_exec_pkg::*;
  logic step_go;
  logic sel;
  logic rel;
  pointer_update_mode_t mode;
  logic [`OFS_W-1:0] offset;
  logic [`PTR_W-1:0] eff_addr;
  logic [`PTR_W-1:0] ptr0;
  logic [`PTR_W-1:0] ptr1;
  logic load;
  logic load_sel;
  logic [`PTR_W-1:0] load_value;
  modport unit (input step_go, sel, rel, mode, offset, load, load_sel,
                load_value, output eff_addr, ptr0, ptr1);
  modport core (output step_go, sel, rel, mode, offset, load, load_sel,
                load_value, input eff_addr, ptr0, ptr1);
endinterface
`default_nettype wire

// [pointer_unit.sv]
// two 16-bit indirect pointers with their address arithmetic
`timescale 1ns/1ps
`default_nettype none
`include "move_exec_defines.svh"
module pointer_unit (
  input wire logic clock,
  input wire logic rst,
  pointer_if.unit p
);
  import move_exec_pkg::*;

  logic [`PTR_W-1:0] ptr0;
  logic [`PTR_W-1:0] ptr1;
  logic [`PTR_W-1:0] next_ptr0;
  logic [`PTR_W-1:0] next_ptr1;
  logic [`PTR_W-1:0] cur;
  logic [`PTR_W-1:0] stepped;

  // 16-bit add drops the carry out, so the pointer wraps naturally
  function automatic logic [`PTR_W-1:0] step(input logic [`PTR_W-1:0] v,
                                             input logic down);
    step = down ? v - `PTR_STEP : v + `PTR_STEP;
  endfunction

  // ----------------------------------------------------------------
  // address and next pointer
  // ----------------------------------------------------------------
  always_comb begin
    cur = p.sel ? ptr1 : ptr0;
    stepped = step(cur, p.mode[0]);
    if (p.rel) begin
      // sign-extend the 6-bit offset to pointer width
      p.eff_addr = cur + {{(`PTR_W-`OFS_W){p.offset[`OFS_W-1]}},
                          p.offset};
    end else begin
      p.eff_addr = p.mode[1] ? cur : stepped;
    end
    next_ptr0 = ptr0;
    next_ptr1 = ptr1;
    // an instruction step beats a software load in the same cycle
    if (p.step_go && !p.rel) begin
      if (p.sel) begin
        next_ptr1 = stepped;
      end else begin
        next_ptr0 = stepped;
      end
    end else if (p.load) begin
      if (p.load_sel) begin
        next_ptr1 = p.load_value;
      end else begin
        next_ptr0 = p.load_value;
      end
    end
  end

  // register the pointers
  always_ff @(posedge clock) begin
    if (rst) begin
      ptr0 <= `PTR_RESET;
      ptr1 <= `PTR_RESET;
    end else begin
      ptr0 <= next_ptr0;
      ptr1 <= next_ptr1;
    end
  end

  assign p.ptr0 = ptr0;
  assign p.ptr1 = ptr1;
endmodule
`default_nettype wire

// [move_exec.sv]
// execution of the data-move instruction group
`timescale 1ns/1ps
`default_nettype none
`include "move_exec_defines.svh"
module move_exec (
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic EXEC,
  input wire move_exec_pkg::move_op_t OP,
  input wire logic [`FILE_AW-1:0] FILE_ADDR,
  input wire logic DEST_BIT,
  input wire logic PTR_SEL,
  input wire move_exec_pkg::pointer_update_mode_t UPDATE_MODE,
  input wire logic REL_FORM,
  input wire logic [`OFS_W-1:0] OFFSET,
  input wire logic [`WORK_W-1:0] LITERAL,
  input wire logic PTR_LOAD,
  input wire logic PTR_LOAD_SEL,
  input wire logic [`PTR_W-1:0] PTR_LOAD_VALUE,
  input wire logic [`WORK_W-1:0] MEM_RDATA,
  output logic [`PTR_W-1:0] MEM_ADDR,
  output logic MEM_WE,
  output logic [`PTR_W-1:0] MEM_WADDR,
  output logic [`WORK_W-1:0] MEM_WDATA,
  output logic [`WORK_W-1:0] WORK,
  output logic ZERO,
  output logic [`BANK_W-1:0] BANK_SELECT,
  output logic [`PCL_W-1:0] PC_HIGH_LATCH,
  output logic [`PTR_W-1:0] POINTER0,
  output logic [`PTR_W-1:0] POINTER1
);
  import move_exec_pkg::*;

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  pointer_if p ();
  logic [`WORK_W-1:0] file_mem [`FILE_DEPTH];
  logic is_copy;
  logic is_ind;
  logic is_store;
  logic win_hit;
  logic [`WORK_W-1:0] src_value;
  logic [`WORK_W-1:0] next_work;
  logic next_zero;
  logic [`BANK_W-1:0] next_bank;
  logic [`PCL_W-1:0] next_pcl;
  logic next_fwe;
  logic [`WORK_W-1:0] next_fdata;
  logic next_mem_we;
  logic [`PTR_W-1:0] next_mem_waddr;

  // the two lowest file addresses are windows, not storage
  function automatic logic is_window(input logic [`FILE_AW-1:0] a);
    is_window = (a == `WINDOW0_ADDR) || (a == `WINDOW1_ADDR);
  endfunction

  pointer_unit u_ptr (
    .clock(CLOCK),
    .rst(RST),
    .p(p)
  );

  // ----------------------------------------------------------------
  // decode and pointer control
  // ----------------------------------------------------------------
  always_comb begin
    is_copy = EXEC && (OP == FILE_COPY_OP);
    is_ind = EXEC && (OP == INDIRECT_LOAD_OP);
    is_store = EXEC && (OP == WORK_STORE_OP);
    win_hit = is_window(FILE_ADDR);
  end

  // a window access borrows the pointer but never steps it
  assign p.step_go = is_ind;
  assign p.sel = is_ind ? PTR_SEL : FILE_ADDR[0];
  assign p.rel = REL_FORM;
  assign p.mode = UPDATE_MODE;
  assign p.offset = OFFSET;
  assign p.load = PTR_LOAD;
  assign p.load_sel = PTR_LOAD_SEL;
  assign p.load_value = PTR_LOAD_VALUE;

  // read address on the data bus: pointer arithmetic or window target
  always_comb begin
    if (is_ind) begin
      MEM_ADDR = p.eff_addr;
    end else begin
      MEM_ADDR = FILE_ADDR[0] ? p.ptr1 : p.ptr0;
    end
  end

  // operand fetch: windows redirect to the bus
  always_comb begin
    if (is_ind || win_hit) begin
      src_value = MEM_RDATA;
    end else begin
      src_value = file_mem[FILE_ADDR];
    end
  end

  // ----------------------------------------------------------------
  // next state of work, flags and literal registers
  // ----------------------------------------------------------------
  always_comb begin
    next_work = WORK;
    next_zero = ZERO; // flags hold unless copy or indirect load
    next_bank = BANK_SELECT;
    next_pcl = PC_HIGH_LATCH;
    next_fwe = 1'b0;
    next_fdata = WORK;
    next_mem_we = 1'b0;
    next_mem_waddr = MEM_ADDR;
    if (EXEC) begin
      unique case (OP)
        FILE_COPY_OP: begin
          next_zero = (src_value == 8'h00);
          if (DEST_BIT) begin
            // writing back the same value makes this a flag test
            next_fdata = src_value;
            next_fwe = !win_hit;
            next_mem_we = win_hit;
          end else begin
            next_work = src_value;
          end
        end
        INDIRECT_LOAD_OP: begin
          next_work = MEM_RDATA;
          next_zero = (MEM_RDATA == 8'h00);
        end
        BANK_LITERAL_OP: begin
          next_bank = LITERAL[`BANK_W-1:0];
        end
        PC_LATCH_LITERAL_OP: begin
          next_pcl = LITERAL[`PCL_W-1:0];
        end
        WORK_LITERAL_OP: begin
          next_work = LITERAL;
        end
        WORK_STORE_OP: begin
          next_fdata = WORK;
          next_fwe = !win_hit;
          next_mem_we = win_hit;
        end
        default: begin
          next_work = WORK; // unknown code: nothing changes
        end
      endcase
    end
  end

  // commit at the end of the one instruction cycle
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      WORK <= `WORK_RESET;
      ZERO <= 1'b0;
      BANK_SELECT <= `BANK_RESET;
      PC_HIGH_LATCH <= `PCL_RESET;
      MEM_WE <= 1'b0;
      MEM_WADDR <= `PTR_RESET;
      MEM_WDATA <= `WORK_RESET;
    end else begin
      WORK <= next_work;
      ZERO <= next_zero;
      BANK_SELECT <= next_bank;
      PC_HIGH_LATCH <= next_pcl;
      MEM_WE <= next_mem_we;
      MEM_WADDR <= next_mem_waddr;
      MEM_WDATA <= next_fdata;
    end
  end

  // file storage; contents are not cleared by reset, as in real RAM
  always_ff @(posedge CLOCK) begin
    if (next_fwe) begin
      file_mem[FILE_ADDR] <= next_fdata;
    end
  end

  assign POINTER0 = p.ptr0;
  assign POINTER1 = p.ptr1;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RST);

  sequence s_ind_step;
    is_ind && !REL_FORM && !PTR_SEL;
  endsequence
  sequence s_ptr0_moved;
    POINTER0 != $past(POINTER0);
  endsequence

  a_copy_to_work: assert property (
    is_copy && !DEST_BIT |=> WORK == $past(src_value))
    else $error("file copy did not reach work");
  a_copy_zero: assert property (
    is_copy |=> ZERO == ($past(src_value) == 8'h00) &&
      ($stable(WORK) || !$past(DEST_BIT)))
    else $error("file copy zero flag wrong");
  a_ind_load: assert property (
    is_ind |=> WORK == $past(MEM_RDATA) && ZERO == (WORK == 8'h00))
    else $error("indirect load result wrong");
  a_mode_step: assert property (
    s_ind_step |-> (MEM_ADDR == (UPDATE_MODE[1] ? POINTER0 :
      (UPDATE_MODE[0] ? POINTER0 - 16'h0001 : POINTER0 + 16'h0001)))
      ##1 s_ptr0_moved)
    else $error("pointer mode decode wrong");
  a_rel_keep: assert property (
    is_ind && REL_FORM && !PTR_LOAD |-> MEM_ADDR == (PTR_SEL ? POINTER1 :
      POINTER0) + {{10{OFFSET[5]}}, OFFSET} ##1
      $stable(POINTER0) && $stable(POINTER1))
    else $error("relative form moved pointer");
  a_window_redir: assert property (
    is_store && win_hit |=> MEM_WE &&
      MEM_WADDR == $past(FILE_ADDR[0] ? POINTER1 : POINTER0) &&
      MEM_WDATA == $past(WORK))
    else $error("window store not redirected");
  a_ptr_wrap: assert property (
    (s_ind_step and (UPDATE_MODE == POST_INC && POINTER0 == 16'hFFFF))
      |=> POINTER0 == 16'h0000)
    else $error("pointer did not wrap");
  a_bank_load: assert property (
    EXEC && OP == BANK_LITERAL_OP |=>
      BANK_SELECT == $past(LITERAL[4:0]) && $stable(ZERO))
    else $error("bank literal load wrong");
  a_pcl_load: assert property (
    EXEC && OP == PC_LATCH_LITERAL_OP |=>
      PC_HIGH_LATCH == $past(LITERAL[6:0]) && $stable(ZERO))
    else $error("pc latch literal load wrong");
  a_work_literal: assert property (
    EXEC && OP == WORK_LITERAL_OP |=> WORK == $past(LITERAL) &&
      $stable(ZERO))
    else $error("work literal load wrong");
  a_store_flags: assert property (
    is_store |=> $stable(ZERO) && $stable(WORK))
    else $error("store changed work or flags");
  a_flag_hold: assert property (
    !is_copy && !is_ind |=> $stable(ZERO))
    else $error("zero flag moved without cause");
  a_one_cycle: assert property (
    EXEC && OP == WORK_LITERAL_OP ##1 EXEC && OP == WORK_STORE_OP &&
      FILE_ADDR == `WINDOW0_ADDR |=> MEM_WDATA == $past(LITERAL, 2))
    else $error("move did not finish in one cycle");
endmodule
`default_nettype wire

// [tb_move_exec.sv]
// self-checking bench for the move-instruction execution block
`timescale 1ns/1ps
`default_nettype none
module tb_move_exec;
  import move_exec_pkg::*;
  // ----------------------------------------
  // stimulus and observed signals
  // ----------------------------------------
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic exec = 1'b0;
  move_op_t op = WORK_LITERAL_OP;
  logic [6:0] file_addr = 7'h00;
  logic dest_bit = 1'b0;
  logic ptr_sel = 1'b0;
  pointer_update_mode_t update_mode = PRE_INC;
  logic rel_form = 1'b0;
  logic [5:0] offset = 6'h00;
  logic [7:0] literal = 8'h00;
  logic ptr_load = 1'b0;
  logic ptr_load_sel = 1'b0;
  logic [15:0] ptr_load_value = 16'h0000;
  logic [7:0] mem_rdata, mem_wdata, work;
  logic [15:0] mem_addr, mem_waddr, pointer0, pointer1;
  logic mem_we, zero;
  logic [4:0] bank_select;
  logic [6:0] pc_high_latch;
  int err_total = 0;
  int check_count = 0;
  int cycles = 0;

  // data bus answers in the same cycle; address 003C reads as zero
  function automatic logic [7:0] data_at(input logic [15:0] a);
    return a[7:0] ^ 8'h3C;
  endfunction
  assign mem_rdata = data_at(mem_addr);

  move_exec uut (.CLOCK(clock), .RST(rst), .EXEC(exec), .OP(op),
    .FILE_ADDR(file_addr), .DEST_BIT(dest_bit), .PTR_SEL(ptr_sel),
    .UPDATE_MODE(update_mode), .REL_FORM(rel_form), .OFFSET(offset),
    .LITERAL(literal), .PTR_LOAD(ptr_load), .PTR_LOAD_SEL(ptr_load_sel),
    .PTR_LOAD_VALUE(ptr_load_value), .MEM_RDATA(mem_rdata),
    .MEM_ADDR(mem_addr), .MEM_WE(mem_we), .MEM_WADDR(mem_waddr),
    .MEM_WDATA(mem_wdata), .WORK(work), .ZERO(zero),
    .BANK_SELECT(bank_select), .PC_HIGH_LATCH(pc_high_latch),
    .POINTER0(pointer0), .POINTER1(pointer1));

  // 200 MHz clock
  initial begin
    forever #2.5 clock = ~clock;
  end

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict;
    $display("mismatches %0d, checks %0d", err_total, check_count);
    if (err_total == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // one instruction; a returns the read address seen mid-cycle
  task automatic run(input move_op_t o, input logic [6:0] f,
      input logic d, input logic s, input pointer_update_mode_t m,
      input logic r, input logic [5:0] k, input logic [7:0] l,
      output logic [15:0] a);
    @(posedge clock);
    #1;
    exec = 1'b1;
    op = o;
    file_addr = f;
    dest_bit = d;
    ptr_sel = s;
    update_mode = m;
    rel_form = r;
    offset = k;
    literal = l;
    #1 a = mem_addr;
    @(posedge clock);
    #1 exec = 1'b0;
  endtask

  task automatic lit(input move_op_t o, input logic [7:0] l);
    logic [15:0] a;
    run(o, 7'h00, 1'b0, 1'b0, PRE_INC, 1'b0, 6'h00, l, a);
  endtask

  task automatic fop(input move_op_t o, input logic [6:0] f,
      input logic d, output logic [15:0] a);
    run(o, f, d, 1'b0, PRE_INC, 1'b0, 6'h00, 8'h00, a);
  endtask

  task automatic load_ptr(input logic s, input logic [15:0] v);
    @(posedge clock);
    #1;
    ptr_load = 1'b1;
    ptr_load_sel = s;
    ptr_load_value = v;
    @(posedge clock);
    #1 ptr_load = 1'b0;
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic test_reset;
    check(work, 8'h00);
    check(zero, 1'b0);
    check(bank_select, 5'h00);
    check(pc_high_latch, 7'h00);
    check(pointer0, 16'h0000);
    check(pointer1, 16'h0000);
    check(mem_we, 1'b0);
    check(mem_waddr, 16'h0000);
    check(mem_wdata, 8'h00);
  endtask

  // zero flag must follow the copied value even when d=1
  task automatic test_copy;
    logic [15:0] a;
    lit(WORK_LITERAL_OP, 8'h5A);
    fop(WORK_STORE_OP, 7'h7F, 1'b0, a);
    lit(WORK_LITERAL_OP, 8'h00);
    fop(WORK_STORE_OP, 7'h02, 1'b0, a);
    fop(FILE_COPY_OP, 7'h7F, 1'b0, a);
    check(work, 8'h5A);
    check(zero, 1'b0);
    fop(FILE_COPY_OP, 7'h02, 1'b0, a);
    check(work, 8'h00);
    check(zero, 1'b1);
    fop(FILE_COPY_OP, 7'h7F, 1'b1, a);
    check(work, 8'h00);
    check(zero, 1'b0);
    fop(FILE_COPY_OP, 7'h7F, 1'b0, a);
    check(work, 8'h5A);
    fop(FILE_COPY_OP, 7'h02, 1'b1, a);
    check(zero, 1'b1);
  endtask

  // enters with the zero flag set; literals and stores keep it
  task automatic test_literal;
    logic [15:0] a;
    lit(WORK_LITERAL_OP, 8'hC3);
    check(work, 8'hC3);
    check(zero, 1'b1);
    lit(BANK_LITERAL_OP, 8'hFF);
    check(bank_select, 5'h1F);
    check(work, 8'hC3);
    lit(BANK_LITERAL_OP, 8'h0F);
    check(bank_select, 5'h0F);
    check(zero, 1'b1);
    lit(PC_LATCH_LITERAL_OP, 8'hFF);
    check(pc_high_latch, 7'h7F);
    check(zero, 1'b1);
    fop(WORK_STORE_OP, 7'h05, 1'b0, a);
    check(zero, 1'b1);
  endtask

  // every mode on both pointers, starting at the top to force wraps
  task automatic test_indirect;
    logic [15:0] p [2];
    logic [15:0] a, ea, nx;
    p[0] = 16'hFFFF;
    p[1] = 16'hFFFF;
    load_ptr(1'b0, 16'hFFFF);
    load_ptr(1'b1, 16'hFFFF);
    for (int s = 0; s < 2; s++) begin
      for (int m = 0; m < 4; m++) begin
        nx = m[0] ? p[s] - 16'h0001 : p[s] + 16'h0001;
        ea = m[1] ? p[s] : nx;
        run(INDIRECT_LOAD_OP, 7'h00, 1'b0, s[0],
          pointer_update_mode_t'(m[1:0]), 1'b0, 6'h00, 8'h00, a);
        p[s] = nx;
        check(a, ea);
        check(work, data_at(ea));
        check(zero, 1'b0);
        check(pointer0, p[0]);
        check(pointer1, p[1]);
      end
    end
    load_ptr(1'b1, 16'h005C);
    run(INDIRECT_LOAD_OP, 7'h00, 1'b0, 1'b1, POST_DEC, 1'b1, 6'h20,
      8'h00, a);
    check(a, 16'h003C);
    check(zero, 1'b1);
    check(pointer1, 16'h005C);
    run(INDIRECT_LOAD_OP, 7'h00, 1'b0, 1'b1, PRE_INC, 1'b1, 6'h1F,
      8'h00, a);
    check(a, 16'h007B);
    check(work, 8'h47);
    check(zero, 1'b0);
    check(pointer1, 16'h005C);
  endtask

  // file addresses 0 and 1 go out on the data bus at the pointer
  task automatic test_window;
    logic [15:0] a;
    load_ptr(1'b0, 16'h1234);
    lit(WORK_LITERAL_OP, 8'hA5);
    fop(WORK_STORE_OP, 7'h00, 1'b0, a);
    check(mem_we, 1'b1);
    check(mem_waddr, 16'h1234);
    check(mem_wdata, 8'hA5);
    @(posedge clock);
    #1 check(mem_we, 1'b0);
    fop(FILE_COPY_OP, 7'h01, 1'b0, a);
    check(a, 16'h005C);
    check(work, 8'h60);
    fop(FILE_COPY_OP, 7'h00, 1'b1, a);
    check(a, 16'h1234);
    check(mem_we, 1'b1);
    check(mem_wdata, 8'h08);
    check(work, 8'h60);
    // back-to-back literal then window store, no idle cycle between
    @(posedge clock);
    #1;
    exec = 1'b1;
    op = WORK_LITERAL_OP;
    literal = 8'h3C;
    @(posedge clock);
    #1;
    op = WORK_STORE_OP;
    file_addr = 7'h00;
    dest_bit = 1'b0;
    @(posedge clock);
    #1 exec = 1'b0;
    check(mem_we, 1'b1);
    check(mem_waddr, 16'h1234);
    check(mem_wdata, 8'h3C);
    check(work, 8'h3C);
  endtask

  // ----------------------------------------
  // sequence and hang guard
  // ----------------------------------------
  initial begin
    repeat (3) @(posedge clock);
    #1 rst = 1'b0;
    test_reset;
    test_copy;
    test_literal;
    test_indirect;
    test_window;
    // mid-run reset must bring pointers and registers back
    @(posedge clock);
    #1 rst = 1'b1;
    @(posedge clock);
    #1 rst = 1'b0;
    test_reset;
    give_verdict;
  end

  // the whole run needs about 75 cycles
  always @(posedge clock) begin
    cycles++;
    if (cycles == 1000) begin
      err_total++;
      give_verdict;
    end
  end
endmodule
`default_nettype wire
